/* hw/dsoc_consts.vh */
// constants for the drive speed output and coil detect block
// assumes pclk at 200 MHz and APB register access
// Behaviour
// - specified-speed output on while speed below threshold
// - specified-speed indication drives digital_out_2 only
// - multi-axis output is AND across the axes enabled in axis_en
// - servo speed unit from bit D
// - servo threshold range 0 to 32767
// - servo out2 select bits 9-8, 01 enables
// - spindle command clamp 33750 or 135000 r/min
// - spindle threshold range 0 to 32767
// - spindle out2 enabled by bit C
// - servo digital_in_1 door or battery by F-C
// - spindle digital_in_1 door or proximity by F-C
// - spindle digital_in_3 emergency stop when field equals 59
// - fixed brake, coil and contactor outputs
// - compare speed to setpoint, report speed_detect_flag
// - flag on below setpoint, setpoint 10 to 32767
// - hysteresis applied above setpoint only, no chatter
// - hysteresis 10 to 1000, default 30
`ifndef DSOC_CONSTS_VH
`define DSOC_CONSTS_VH
`define DSOC_A_SV_FUNC2     12'h000
`define DSOC_A_SV_THR0      12'h004
`define DSOC_A_SV_THR1      12'h008
`define DSOC_A_SV_THR2      12'h00C
`define DSOC_A_SV_FUNC5     12'h010
`define DSOC_A_SP_SPINDLE_SPEC_WORD_2     12'h014
`define DSOC_A_SP_THR       12'h018
`define DSOC_A_SP_FUNC9     12'h01C
`define DSOC_A_SP_INSEL     12'h020
`define DSOC_A_SP_INFUNC3   12'h024
`define DSOC_A_SD_SET       12'h028
`define DSOC_A_SD_HYS       12'h02C
`define DSOC_A_SV_SPD0      12'h030
`define DSOC_A_SV_SPD1      12'h034
`define DSOC_A_SV_SPD2      12'h038
`define DSOC_A_SP_SPD       12'h03C
`define DSOC_A_SP_CMD       12'h040
`define DSOC_A_CTRL         12'h044
`define DSOC_A_STATUS       12'h048
`define DSOC_A_CMD_OUT      12'h04C
`define DSOC_B_UNIT         13
`define DSOC_B_OUT2_HI      9
`define DSOC_B_OUT2_LO      8
`define DSOC_B_SPD_LIM      8
`define DSOC_B_SP_OUT2      12
`define DSOC_B_IN1_HI       15
`define DSOC_B_IN1_LO       12
`define DSOC_OUT2_SPEC      2'h1
`define DSOC_IN1_DOOR       4'h1
`define DSOC_IN1_ALT        4'h2
`define DSOC_EMG_CODE       8'h3B
`define DSOC_THR_MAX        15'h7FFF
`define DSOC_SD_MIN         15'h000A
`define DSOC_HYS_MIN        10'h00A
`define DSOC_HYS_MAX        10'h3E8
`define DSOC_HYS_RST        10'h01E
`define DSOC_SD_RST         15'h000A
`define DSOC_LIM_LO         18'h083D6
`define DSOC_LIM_HI         18'h20F58
`endif

/* hw/dsoc_top.v */
// peripheral io logic: specified-speed output, coil speed detect
// assumes speeds are written by the control loop over APB each cycle
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "dsoc_consts.vh"
module dsoc_top
(
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // digital inputs
   input  wire        digital_in_1,
   input  wire        digital_in_3,
   // controller side
   input  wire        low_coil_select,
   input  wire        brake_release,
   input  wire        contactor_on,
   input  wire        spindle_mode,
   output reg         speed_detect_flag,
   // digital outputs
   output reg         digital_out_1,
   output reg         digital_out_2,
   output reg         digital_out_3,
   output reg         door_state,
   output reg         battery_low,
   output reg         proximity_switch,
   output reg         external_emergency_stop
);
   reg [15:0] servo_function_2;
   reg [15:0] servo_function_5;
   reg [15:0] spindle_spec_2;
   reg [15:0] spindle_function_9;
   reg [15:0] spindle_input_select;
   reg [15:0] spindle_input_func_3;
   reg [14:0] sv_thr [0:2];
   reg [14:0] spindle_spec_speed_threshold;
   reg [14:0] speed_detect_setpoint;
   reg [9:0]  speed_detect_hysteresis;
   reg [14:0] sv_spd [0:2];
   reg [14:0] sp_spd;
   reg [17:0] sp_cmd;
   reg [17:0] sp_cmd_lim;
   reg [2:0]  axis_en;
   reg        servo_spec_ok;
   reg        spindle_spec_ok;
   reg [31:0] next_rdata;
   reg        next_err;
   reg        next_spec;
   wire       acc;
   wire       wr;
   wire [3:0] sv_in1;
   wire [3:0] sp_in1;
   wire [17:0] lim;
   integer    i;
   integer    j;

   // below threshold: equality counts as not below
   function below;
      input [14:0] spd;
      input [14:0] thr;
      begin
         below = (spd < thr);
      end
   endfunction

   // clamp a setting into its legal range
   function [14:0] clamp15;
      input [14:0] v;
      input [14:0] lo;
      begin
         clamp15 = (v < lo) ? lo : v;
      end
   endfunction

   assign acc = psel & penable & ~pready;
   assign wr  = acc & pwrite;
   assign sv_in1 = servo_function_5[`DSOC_B_IN1_HI:`DSOC_B_IN1_LO];
   assign sp_in1 = spindle_input_select[`DSOC_B_IN1_HI:`DSOC_B_IN1_LO];
   assign lim = spindle_spec_2[`DSOC_B_SPD_LIM] ? `DSOC_LIM_HI
                                                : `DSOC_LIM_LO;

   always @*
   begin
      next_err = 1'b0;
      if (paddr == `DSOC_A_SV_FUNC2)
         next_rdata = {16'h0000, servo_function_2};
      else if (paddr == `DSOC_A_SV_THR0)
         next_rdata = {17'h00000, sv_thr[0]};
      else if (paddr == `DSOC_A_SV_THR1)
         next_rdata = {17'h00000, sv_thr[1]};
      else if (paddr == `DSOC_A_SV_THR2)
         next_rdata = {17'h00000, sv_thr[2]};
      else if (paddr == `DSOC_A_SV_FUNC5)
         next_rdata = {16'h0000, servo_function_5};
      else if (paddr == `DSOC_A_SP_SPINDLE_SPEC_WORD_2)
         next_rdata = {16'h0000, spindle_spec_2};
      else if (paddr == `DSOC_A_SP_THR)
         next_rdata = {17'h00000, spindle_spec_speed_threshold};
      else if (paddr == `DSOC_A_SP_FUNC9)
         next_rdata = {16'h0000, spindle_function_9};
      else if (paddr == `DSOC_A_SP_INSEL)
         next_rdata = {16'h0000, spindle_input_select};
      else if (paddr == `DSOC_A_SP_INFUNC3)
         next_rdata = {16'h0000, spindle_input_func_3};
      else if (paddr == `DSOC_A_SD_SET)
         next_rdata = {17'h00000, speed_detect_setpoint};
      else if (paddr == `DSOC_A_SD_HYS)
         next_rdata = {22'h000000, speed_detect_hysteresis};
      else if (paddr == `DSOC_A_SV_SPD0)
         next_rdata = {17'h00000, sv_spd[0]};
      else if (paddr == `DSOC_A_SV_SPD1)
         next_rdata = {17'h00000, sv_spd[1]};
      else if (paddr == `DSOC_A_SV_SPD2)
         next_rdata = {17'h00000, sv_spd[2]};
      else if (paddr == `DSOC_A_SP_SPD)
         next_rdata = {17'h00000, sp_spd};
      else if (paddr == `DSOC_A_SP_CMD)
         next_rdata = {14'h0000, sp_cmd};
      else if (paddr == `DSOC_A_CTRL)
         next_rdata = {29'h00000000, axis_en};
      else if (paddr == `DSOC_A_STATUS)
         next_rdata = {24'h000000, external_emergency_stop,
                       proximity_switch, battery_low, door_state,
                       speed_detect_flag, digital_out_2,
                       spindle_spec_ok, servo_spec_ok};
      else if (paddr == `DSOC_A_CMD_OUT)
         next_rdata = {14'h0000, sp_cmd_lim};
      else
      begin
         next_rdata = 32'h00000000;
         next_err   = 1'b1;
      end
   end

   // apb slave: one wait state, answer in second access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= acc;
         pslverr <= acc & next_err;
         prdata  <= (acc & ~pwrite) ? next_rdata : 32'h00000000;
      end
   end

   // register writes; settings outside their range clamp here
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         servo_function_2             <= 16'h0000;
         servo_function_5             <= 16'h0000;
         spindle_spec_2               <= 16'h0000;
         spindle_function_9           <= 16'h0000;
         spindle_input_select         <= 16'h0000;
         spindle_input_func_3         <= 16'h0000;
         spindle_spec_speed_threshold <= 15'h0000;
         speed_detect_setpoint        <= `DSOC_SD_RST;
         speed_detect_hysteresis      <= `DSOC_HYS_RST;
         sp_spd                       <= 15'h0000;
         sp_cmd                       <= 18'h00000;
         axis_en                      <= 3'h1;
         for (i = 0; i < 3; i = i + 1)
         begin
            sv_thr[i] <= 15'h0000;
            sv_spd[i] <= 15'h0000;
         end
      end
      else if (wr)
      begin
         if (paddr == `DSOC_A_SV_FUNC2)
            servo_function_2 <= pwdata[15:0];
         else if (paddr == `DSOC_A_SV_THR0)
            sv_thr[0] <= pwdata[14:0];
         else if (paddr == `DSOC_A_SV_THR1)
            sv_thr[1] <= pwdata[14:0];
         else if (paddr == `DSOC_A_SV_THR2)
            sv_thr[2] <= pwdata[14:0];
         else if (paddr == `DSOC_A_SV_FUNC5)
            servo_function_5 <= pwdata[15:0];
         else if (paddr == `DSOC_A_SP_SPINDLE_SPEC_WORD_2)
            spindle_spec_2 <= pwdata[15:0];
         else if (paddr == `DSOC_A_SP_THR)
            spindle_spec_speed_threshold <= pwdata[14:0];
         else if (paddr == `DSOC_A_SP_FUNC9)
            spindle_function_9 <= pwdata[15:0];
         else if (paddr == `DSOC_A_SP_INSEL)
            spindle_input_select <= pwdata[15:0];
         else if (paddr == `DSOC_A_SP_INFUNC3)
            spindle_input_func_3 <= pwdata[15:0];
         else if (paddr == `DSOC_A_SD_SET)
            speed_detect_setpoint <= clamp15(pwdata[14:0],
                                             `DSOC_SD_MIN);
         else if (paddr == `DSOC_A_SD_HYS)
         begin
            if (pwdata[15:0] < {6'h00, `DSOC_HYS_MIN})
               speed_detect_hysteresis <= `DSOC_HYS_MIN;
            else if (pwdata[15:0] > {6'h00, `DSOC_HYS_MAX})
               speed_detect_hysteresis <= `DSOC_HYS_MAX;
            else
               speed_detect_hysteresis <= pwdata[9:0];
         end
         else if (paddr == `DSOC_A_SV_SPD0)
            sv_spd[0] <= pwdata[14:0];
         else if (paddr == `DSOC_A_SV_SPD1)
            sv_spd[1] <= pwdata[14:0];
         else if (paddr == `DSOC_A_SV_SPD2)
            sv_spd[2] <= pwdata[14:0];
         else if (paddr == `DSOC_A_SP_SPD)
            sp_spd <= pwdata[14:0];
         else if (paddr == `DSOC_A_SP_CMD)
            sp_cmd <= pwdata[17:0];
         else if (paddr == `DSOC_A_CTRL)
            axis_en <= pwdata[2:0];
      end
   end

   // servo comparisons: speed and threshold share the unit from bit D
   always @*
   begin
      next_spec = 1'b1;
      for (j = 0; j < 3; j = j + 1)
         if (axis_en[j] && !below(sv_spd[j], sv_thr[j]))
            next_spec = 1'b0;
   end

   // per-cycle compares and mode-dependent pin functions
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         servo_spec_ok           <= 1'b0;
         spindle_spec_ok         <= 1'b0;
         speed_detect_flag       <= 1'b0;
         sp_cmd_lim              <= 18'h00000;
         digital_out_1           <= 1'b0;
         digital_out_2           <= 1'b0;
         digital_out_3           <= 1'b0;
         door_state              <= 1'b0;
         battery_low             <= 1'b0;
         proximity_switch        <= 1'b0;
         external_emergency_stop <= 1'b0;
      end
      else
      begin
         servo_spec_ok   <= next_spec;
         spindle_spec_ok <= below(sp_spd,
                                  spindle_spec_speed_threshold);
         sp_cmd_lim <= (sp_cmd > lim) ? lim : sp_cmd;
         // hysteresis: on below setpoint, off at or above setpoint+width
         // sum kept 16 bits wide so setpoint plus width cannot wrap
         if (below(sp_spd, speed_detect_setpoint))
            speed_detect_flag <= 1'b1;
         else if ({1'b0, sp_spd} >= {1'b0, speed_detect_setpoint}
                  + {6'h00, speed_detect_hysteresis})
            speed_detect_flag <= 1'b0;
         // spindle: coil and contactor; servo: brake on digital_out_1
         if (spindle_mode)
         begin
            digital_out_1 <= low_coil_select;
            digital_out_3 <= contactor_on;
            digital_out_2 <= spindle_function_9[`DSOC_B_SP_OUT2] &
                             spindle_spec_ok;
            door_state       <= (sp_in1 == `DSOC_IN1_DOOR) &
                                digital_in_1;
            proximity_switch <= (sp_in1 == `DSOC_IN1_ALT) &
                                digital_in_1;
            battery_low      <= 1'b0;
            external_emergency_stop <=
               (spindle_input_func_3[7:0] == `DSOC_EMG_CODE) &
               digital_in_3;
         end
         else
         begin
            digital_out_1 <= brake_release;
            digital_out_3 <= 1'b0;
            digital_out_2 <= (servo_function_5[`DSOC_B_OUT2_HI:
                             `DSOC_B_OUT2_LO] == `DSOC_OUT2_SPEC) &
                             servo_spec_ok;
            door_state       <= (sv_in1 == `DSOC_IN1_DOOR) &
                                digital_in_1;
            battery_low      <= (sv_in1 == `DSOC_IN1_ALT) &
                                digital_in_1;
            proximity_switch <= 1'b0;
            external_emergency_stop <= 1'b0;
         end
      end
   end
endmodule

/* test/dsoc_nc_model.sv */
// controller model: turns the speed flag into a coil command
// assumes pclk and the active-low reset of the block
`timescale 1ns/100ps
module dsoc_nc_model
(
   // clock and reset
   input  wire pclk,
   input  wire presetn,
   // drive side
   input  wire speed_detect_flag,
   input  wire coil_fixed,
   output reg  low_coil_select
);
   reg [3:0] lag;
   // slow answer: five cycles of judging other conditions
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         lag             <= 4'h0;
         low_coil_select <= 1'b0;
      end
      else
      begin
         lag             <= {lag[2:0], speed_detect_flag & ~coil_fixed};
         low_coil_select <= lag[3];
      end
endmodule

/* test/dsoc_monitor.sv */
// port checker for the speed output block
// assumes one clock pclk and async active-low presetn
`timescale 1ns/100ps
module dsoc_monitor
(
   // apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // io
   input wire        spindle_mode,
   input wire        digital_in_1,
   input wire        digital_in_3,
   input wire        speed_detect_flag,
   input wire        digital_out_2,
   input wire        digital_out_3,
   input wire        door_state,
   input wire        battery_low,
   input wire        proximity_switch,
   input wire        external_emergency_stop
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read answer");
   unmapped_err_a: assert property (pready && paddr > 12'h04C |-> pslverr)
      else $error("unmapped access not refused");
   servo_in_a: assert property (
      (!spindle_mode)[*3] |-> !external_emergency_stop && !proximity_switch)
      else $error("spindle input decoded in servo mode");
   spindle_batt_a: assert property (spindle_mode[*3] |-> !battery_low)
      else $error("battery input decoded in spindle mode");
   door_follow_a: assert property (
      (!digital_in_1)[*3] |-> !door_state)
      else $error("door state without input");
   emg_follow_a: assert property (
      (!digital_in_3)[*3] |-> !external_emergency_stop)
      else $error("emergency stop without input");
   contactor_servo_a: assert property (
      (!spindle_mode)[*3] |-> !digital_out_3)
      else $error("contactor output driven in servo mode");
   flag_c: cover property ($rose(speed_detect_flag));
   out2_c: cover property ($rose(digital_out_2));
   err_c: cover property (pslverr);
endmodule
bind dsoc_top dsoc_monitor i_dsoc_monitor (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .spindle_mode, .digital_in_1,
   .digital_in_3, .speed_detect_flag, .digital_out_2, .digital_out_3,
   .door_state, .battery_low, .proximity_switch,
   .external_emergency_stop);

/* test/tb.sv */
// testbench: apb register tasks and io checks of the speed block
// assumes the register offsets of the block's constants header
`timescale 1ns/100ps
`include "dsoc_consts.vh"
module tb;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         digital_in_1 = 1'b0;
   reg         digital_in_3 = 1'b0;
   reg         spindle_mode = 1'b0;
   reg         coil_fixed = 1'b0;
   reg         brake_release = 1'b0;
   reg         contactor_on = 1'b1;
   wire [31:0] prdata;
   wire        pready, pslverr, low_coil_select, speed_detect_flag;
   wire        digital_out_1, digital_out_2, digital_out_3;
   wire        door_state, battery_low, proximity_switch;
   wire        external_emergency_stop;
   integer     bad_count = 0;
   integer     checks_done = 0;
   integer     i;
   reg  [31:0] rdat;
   reg         rerr;
   reg  [31:0] spd [0:4];
   reg         exf [0:4];
   always #2.5 pclk = ~pclk;
   dsoc_top i_dsoc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .digital_in_1, .digital_in_3,
      .low_coil_select, .brake_release, .contactor_on,
      .spindle_mode, .speed_detect_flag, .digital_out_1, .digital_out_2,
      .digital_out_3, .door_state, .battery_low, .proximity_switch,
      .external_emergency_stop);
   dsoc_nc_model i_dsoc_nc_model (.pclk, .presetn, .speed_detect_flag,
      .coil_fixed, .low_coil_select);
   task stop_test;
      begin
         if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chkw(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chkb(input got, input exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20)
         begin
            @(posedge pclk);
            n = n + 1;
         end
         if (n == 20)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t no ready from slave", $time);
            stop_test;
         end
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input [11:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chkw(rdat, e);
         chkb(rerr, 1'b0);
      end
   endtask
   task wt(input integer n);
      begin
         repeat (n) @(posedge pclk);
         #1;
      end
   endtask
   initial
   begin
      spd[0] = 32'h000003E7;
      spd[1] = 32'h00000405;
      spd[2] = 32'h00000406;
      spd[3] = 32'h000003E9;
      spd[4] = 32'h000003E7;
      exf[0] = 1'b1;
      exf[1] = 1'b1;
      exf[2] = 1'b0;
      exf[3] = 1'b0;
      exf[4] = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`DSOC_A_SD_SET, 32'hA);
      rdc(`DSOC_A_SD_HYS, 32'h1E);
      apb(1'b0, 12'h050, 32'h0);
      chkb(rerr, 1'b1);
      chkw(rdat, 32'h0);
      wr(`DSOC_A_SD_SET, 32'h5);
      rdc(`DSOC_A_SD_SET, 32'hA);
      wr(`DSOC_A_SD_HYS, 32'h7D0);
      rdc(`DSOC_A_SD_HYS, 32'h3E8);
      wr(`DSOC_A_SD_HYS, 32'h1E);
      wr(`DSOC_A_SV_FUNC2, 32'h2000);
      rdc(`DSOC_A_SV_FUNC2, 32'h2000);
      wr(`DSOC_A_SV_THR0, 32'h7FFF);
      rdc(`DSOC_A_SV_THR0, 32'h7FFF);
      wr(`DSOC_A_SV_FUNC5, 32'h100);
      wr(`DSOC_A_CTRL, 32'h7);
      for (i = 0; i < 3; i = i + 1)
      begin
         wr(`DSOC_A_SV_THR0 + 4 * i, 32'h64);
         wr(`DSOC_A_SV_SPD0 + 4 * i, 32'h63);
      end
      wt(2);
      chkb(digital_out_2, 1'b1);
      wr(`DSOC_A_SV_SPD2, 32'h64);
      wt(2);
      chkb(digital_out_2, 1'b0);
      wr(`DSOC_A_SV_SPD2, 32'h63);
      wr(`DSOC_A_SV_FUNC5, 32'h0);
      wt(2);
      chkb(digital_out_2, 1'b0);
      @(posedge pclk) spindle_mode <= 1'b1;
      wr(`DSOC_A_SP_THR, 32'h1F4);
      wr(`DSOC_A_SP_SPD, 32'h190);
      wt(2);
      chkb(digital_out_2, 1'b0);
      wr(`DSOC_A_SP_FUNC9, 32'h1000);
      wt(2);
      chkb(digital_out_2, 1'b1);
      wr(`DSOC_A_SP_SPD, 32'h1F4);
      wt(2);
      chkb(digital_out_2, 1'b0);
      wr(`DSOC_A_SD_SET, 32'h3E8);
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(`DSOC_A_SP_SPD, spd[i]);
         wt(1);
         chkb(speed_detect_flag, exf[i]);
      end
      wt(8);
      chkb(digital_out_1, 1'b1);
      chkb(digital_out_3, 1'b1);
      @(posedge pclk) contactor_on <= 1'b0;
      wt(2);
      chkb(digital_out_3, 1'b0);
      wr(`DSOC_A_SP_CMD, 32'h3FFFF);
      wr(`DSOC_A_SP_SPINDLE_SPEC_WORD_2, 32'h0);
      rdc(`DSOC_A_CMD_OUT, 32'h83D6);
      wr(`DSOC_A_SP_SPINDLE_SPEC_WORD_2, 32'h100);
      rdc(`DSOC_A_CMD_OUT, 32'h20F58);
      wr(`DSOC_A_SP_INSEL, 32'h1000);
      @(posedge pclk) digital_in_1 <= 1'b1;
      wt(3);
      chkb(door_state, 1'b1);
      wr(`DSOC_A_SP_INSEL, 32'h2000);
      wt(3);
      chkb(proximity_switch, 1'b1);
      wr(`DSOC_A_SP_INFUNC3, 32'h3B);
      @(posedge pclk) digital_in_3 <= 1'b1;
      wt(3);
      chkb(external_emergency_stop, 1'b1);
      wr(`DSOC_A_SP_INFUNC3, 32'h3A);
      wt(3);
      chkb(external_emergency_stop, 1'b0);
      @(posedge pclk) spindle_mode <= 1'b0;
      wr(`DSOC_A_SV_FUNC5, 32'h2000);
      wt(3);
      chkb(battery_low, 1'b1);
      wr(`DSOC_A_SV_FUNC5, 32'h1000);
      wt(3);
      chkb(door_state, 1'b1);
      @(posedge pclk) brake_release <= 1'b1;
      contactor_on <= 1'b1;
      wt(2);
      chkb(digital_out_1, 1'b1);
      chkb(digital_out_3, 1'b0);
      stop_test;
   end
endmodule
